// ### design/fwt_pkg.sv
// Shared constants, types and behaviour notes for the failsafe watchdog timer.
// Notes on behaviour
// - With the tuning pin open, timeout is 10 ms from oscillator and divider.
// - Clear input held static makes the warning a square wave of twice timeout.
// - Oscillator and timer run only with good supply and input above cutoff.
// - Falling edge or low pulse over 150 ns resets timer, warning goes high.
// - A clear before timeout keeps warning high and restarts the count.
// - No clear before timeout: warning toggles each timeout, starting low.
// - No clear in first low phase: halt goes low until clear or power-up.
// - Halt releases one timeout and one clock cycle after the upper threshold is sampled.
// - Clear events are ignored until the power-up delay has finished.
// - A clear during supervision returns warning and halt outputs high.
// - Cutoff overrides timer: halt and power-fail low, warning disabled at once.
// - After cutoff all clears are ignored until a new power-up completes.
// - Power-fail goes low below the warn threshold until upper threshold again.
// - After cutoff, rising above the upper threshold starts a new power-up.
package fwt_pkg;

  // ------------------------------------------------------------------------
  // Timing.
  // ------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ             = 250;
  localparam int unsigned EXPIRY_PERIOD_MS    = 10;
  localparam int unsigned EXPIRY_CYCLES       = EXPIRY_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned TICKS_PER_EXPIRY    = 32;
  localparam int unsigned OSC_DIV_CYCLES      = EXPIRY_CYCLES / TICKS_PER_EXPIRY;
  localparam int unsigned TUNED_TICKS_DEFAULT = 64;
  localparam int unsigned KICK_MIN_NS         = 150;
  localparam int unsigned KICK_MIN_CYCLES     = (KICK_MIN_NS * CLK_MHZ + 999) / 1000;

  // ------------------------------------------------------------------------
  // Output values after reset (all active low, so low means asserted).
  // ------------------------------------------------------------------------
  localparam logic WARN_RST_VAL = 1'b1;
  localparam logic HALT_RST_VAL = 1'b0;
  localparam logic PF_RST_VAL   = 1'b0;

  // ------------------------------------------------------------------------
  // Types.
  // ------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FWT_OFF,
    FWT_POWERUP,
    FWT_WATCH
  } fwt_state_e;

  typedef struct packed {
    logic supply_good_level;
    logic upper_threshold_hit;
    logic warn_threshold_low;
    logic below_cutoff;
  } fwt_levels_s;

  typedef struct packed {
    logic expiry_warning_n;
    logic cpu_halt_n;
    logic power_fail_n;
  } fwt_outs_s;

endpackage

// ### design/fwt_tick_gen.sv
// Oscillator tick divider: one-cycle enable pulse every DIV clock cycles.
`timescale 1ns/1ps
module fwt_tick_gen
#(
  parameter int unsigned DIV = fwt_pkg::OSC_DIV_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic restart,
  output logic      tick
);

  localparam int unsigned W = $clog2(DIV);

  // ------------------------------------------------------------------------
  // Elaboration check.
  // ------------------------------------------------------------------------
  if (DIV < 2)
  begin : g_bad_div
    $error("fwt_tick_gen: DIV must be at least 2");
  end

  logic [W-1:0] div_reg;
  logic [W-1:0] div_next;
  logic         tick_next;
  wire          at_end = (div_reg == W'(DIV - 1));

  // The divider stops and rewinds when halted so each period starts whole.
  assign div_next  = (!run || restart || at_end) ? '0 : div_reg + W'(1);
  assign tick_next = run && !restart && at_end;

  // Counter and tick flop.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_reg <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick    <= tick_next;
    end
  end

endmodule

// ### design/fwt_watchdog.sv
// Top level of the failsafe watchdog timer: sequencer, timer and outputs.
`timescale 1ns/1ps
module fwt_watchdog
#(
  parameter int unsigned OSC_DIV     = fwt_pkg::OSC_DIV_CYCLES,
  parameter int unsigned EXPIRY_TKS  = fwt_pkg::TICKS_PER_EXPIRY,
  parameter int unsigned TUNED_TKS   = fwt_pkg::TUNED_TICKS_DEFAULT,
  parameter int unsigned CNT_W       = 8
)
(
  input  wire logic CLOCK,
  input  wire logic RST,
  input  wire logic KICK_IN_N,
  input  wire logic OSC_TUNE_PIN_OPEN,
  input  wire logic SUPPLY_GOOD_LEVEL,
  input  wire logic UPPER_THRESHOLD_HIT,
  input  wire logic WARN_THRESHOLD_LOW,
  input  wire logic BELOW_CUTOFF_THRESHOLD,
  output logic      EXPIRY_WARNING_N,
  output logic      CPU_HALT_N,
  output logic      POWER_FAIL_N
);

  // ------------------------------------------------------------------------
  // Elaboration checks.
  // ------------------------------------------------------------------------
  if (EXPIRY_TKS < 2 || TUNED_TKS < 2)
  begin : g_bad_ticks
    $error("fwt_watchdog: terminal counts must be at least 2");
  end
  if (EXPIRY_TKS > (1 << CNT_W) || TUNED_TKS > (1 << CNT_W))
  begin : g_bad_width
    $error("fwt_watchdog: CNT_W too narrow for terminal counts");
  end

  // ------------------------------------------------------------------------
  // Input capture.
  // ------------------------------------------------------------------------
  // The clear pin and tuning strap are asynchronous to CLOCK; the comparator
  // levels arrive already synchronised and are only bundled here.
  logic                kick_s1_reg;
  logic                kick_s2_reg;
  logic                kick_prev_reg;
  logic                tune_s1_reg;
  logic                tune_s2_reg;
  fwt_pkg::fwt_levels_s lvl;

  assign lvl = '{supply_good_level:   SUPPLY_GOOD_LEVEL,
                 upper_threshold_hit: UPPER_THRESHOLD_HIT,
                 warn_threshold_low:  WARN_THRESHOLD_LOW,
                 below_cutoff:        BELOW_CUTOFF_THRESHOLD};

  // Two-flop synchronisers and the edge history flop.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      kick_s1_reg   <= 1'b1;
      kick_s2_reg   <= 1'b1;
      kick_prev_reg <= 1'b1;
      tune_s1_reg   <= 1'b1;
      tune_s2_reg   <= 1'b1;
    end
    else
    begin
      kick_s1_reg   <= KICK_IN_N;
      kick_s2_reg   <= kick_s1_reg;
      kick_prev_reg <= kick_s2_reg;
      tune_s1_reg   <= OSC_TUNE_PIN_OPEN;
      tune_s2_reg   <= tune_s1_reg;
    end
  end

  // A falling edge is the clear event; any low pulse of 150 ns spans many
  // clock periods, so edge detection after the synchroniser never misses it.
  wire kick_fall = kick_prev_reg && !kick_s2_reg;

  // ------------------------------------------------------------------------
  // Sequencer state and shared decode.
  // ------------------------------------------------------------------------
  fwt_pkg::fwt_state_e state_reg;
  fwt_pkg::fwt_state_e state_next;
  logic [CNT_W-1:0]    tick_cnt_reg;
  logic [CNT_W-1:0]    tick_cnt_next;
  fwt_pkg::fwt_outs_s  outs_reg;
  fwt_pkg::fwt_outs_s  outs_next;
  logic                osc_tick;

  // Loss of supply or a drop below cutoff stops everything at once.
  wire off_cond  = !lvl.supply_good_level || lvl.below_cutoff;
  wire start_up  = !off_cond && lvl.upper_threshold_hit;
  wire in_watch  = (state_reg == fwt_pkg::FWT_WATCH);
  wire in_pwrup  = (state_reg == fwt_pkg::FWT_POWERUP);
  // Clears only count once supervision runs; power-up and off states drop them.
  wire kick_take = kick_fall && in_watch && !off_cond;
  // A strapped tuning pin selects the alternate oscillator terminal count.
  wire [CNT_W-1:0] last_tick = tune_s2_reg ? CNT_W'(EXPIRY_TKS - 1)
                                           : CNT_W'(TUNED_TKS - 1);
  wire expire    = osc_tick && (tick_cnt_reg == last_tick) && !off_cond;
  wire osc_run   = (in_watch || in_pwrup) && !off_cond;

  // ------------------------------------------------------------------------
  // Oscillator divider.
  // ------------------------------------------------------------------------
  // Rewinding the divider on a clear keeps every timeout a whole period long
  // at the cost of the divider phase following the host's clear timing.
  fwt_tick_gen
  #(
    .DIV     (OSC_DIV)
  )
  u_tick
  (
    .clk     (CLOCK),
    .rst     (RST),
    .run     (osc_run),
    .restart (kick_take),
    .tick    (osc_tick)
  );

  // ------------------------------------------------------------------------
  // Next-state decode.
  // ------------------------------------------------------------------------
  // Off waits for supply and the upper threshold; power-up lasts one period.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      fwt_pkg::FWT_OFF:
      begin
        if (start_up)
          state_next = fwt_pkg::FWT_POWERUP;
      end
      fwt_pkg::FWT_POWERUP:
      begin
        if (off_cond)
          state_next = fwt_pkg::FWT_OFF;
        else if (expire)
          state_next = fwt_pkg::FWT_WATCH;
      end
      fwt_pkg::FWT_WATCH:
      begin
        if (off_cond)
          state_next = fwt_pkg::FWT_OFF;
      end
      default:
        state_next = fwt_pkg::FWT_OFF;
    endcase
  end

  // Tick counter: cleared when stopped or by a clear, wraps each period.
  always_comb
  begin
    if (!osc_run || state_reg == fwt_pkg::FWT_OFF)
      tick_cnt_next = '0;
    else if (kick_take)
      tick_cnt_next = '0;
    else if (expire)
      tick_cnt_next = '0;
    else if (osc_tick)
      tick_cnt_next = tick_cnt_reg + CNT_W'(1);
    else
      tick_cnt_next = tick_cnt_reg;
  end

  // Output decode for warning and halt.
  always_comb
  begin
    outs_next = outs_reg;
    if (off_cond || state_reg == fwt_pkg::FWT_OFF)
    begin
      outs_next.expiry_warning_n = 1'b1;
      outs_next.cpu_halt_n       = 1'b0;
    end
    else if (in_pwrup)
    begin
      outs_next.expiry_warning_n = 1'b1;
      outs_next.cpu_halt_n       = expire;
    end
    else if (kick_take)
    begin
      outs_next.expiry_warning_n = 1'b1;
      outs_next.cpu_halt_n       = 1'b1;
    end
    else if (expire)
    begin
      // Toggling goes on forever without a clear, giving the 2x square wave.
      outs_next.expiry_warning_n = !outs_reg.expiry_warning_n;
      if (!outs_reg.expiry_warning_n)
        outs_next.cpu_halt_n = 1'b0;
    end
    // The power-fail latch: set to low below the warn level, freed by upper.
    if (off_cond)
      outs_next.power_fail_n = 1'b0;
    else if (lvl.warn_threshold_low)
      outs_next.power_fail_n = 1'b0;
    else if (lvl.upper_threshold_hit)
      outs_next.power_fail_n = 1'b1;
  end

  // ------------------------------------------------------------------------
  // State registers.
  // ------------------------------------------------------------------------
  // Kept short: all decisions live in the decode above.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state_reg    <= fwt_pkg::FWT_OFF;
      tick_cnt_reg <= '0;
      outs_reg     <= '{expiry_warning_n: fwt_pkg::WARN_RST_VAL,
                        cpu_halt_n:       fwt_pkg::HALT_RST_VAL,
                        power_fail_n:     fwt_pkg::PF_RST_VAL};
    end
    else
    begin
      state_reg    <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      outs_reg     <= outs_next;
    end
  end

  // Outputs come straight from the output flops.
  assign EXPIRY_WARNING_N = outs_reg.expiry_warning_n;
  assign CPU_HALT_N       = outs_reg.cpu_halt_n;
  assign POWER_FAIL_N     = outs_reg.power_fail_n;

  // ------------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------------
  // A cutoff forces halt and power-fail low and parks the warning high.
  property p_cutoff_override;
    @(posedge CLOCK) disable iff (RST)
    BELOW_CUTOFF_THRESHOLD |=> (!CPU_HALT_N && !POWER_FAIL_N && EXPIRY_WARNING_N);
  endproperty
  a_cutoff_override: assert property (p_cutoff_override)
    else $error("cutoff did not force outputs");

  // Loss of supply stops the timer count and parks the sequencer.
  property p_supply_stop;
    @(posedge CLOCK) disable iff (RST)
    !SUPPLY_GOOD_LEVEL |=> (tick_cnt_reg == '0) && (state_reg == fwt_pkg::FWT_OFF);
  endproperty
  a_supply_stop: assert property (p_supply_stop)
    else $error("timer kept running without supply");

  // A clear taken during supervision frees both outputs on the next edge.
  property p_kick_frees;
    @(posedge CLOCK) disable iff (RST)
    (in_watch && kick_fall && !off_cond) |=> (EXPIRY_WARNING_N && CPU_HALT_N
                                              && tick_cnt_reg == '0);
  endproperty
  a_kick_frees: assert property (p_kick_frees)
    else $error("clear did not free outputs");

  // Clears during power-up change nothing: halt stays low.
  property p_pwrup_ignores;
    @(posedge CLOCK) disable iff (RST)
    (in_pwrup && kick_fall && !expire && !off_cond) |=> !CPU_HALT_N && in_pwrup;
  endproperty
  a_pwrup_ignores: assert property (p_pwrup_ignores)
    else $error("clear acted during power-up");

  // Halt is released only by the power-up expiry or a clear.
  property p_halt_release;
    @(posedge CLOCK) disable iff (RST)
    $rose(CPU_HALT_N) |-> ($past(expire) && $past(in_pwrup)) || $past(kick_take);
  endproperty
  a_halt_release: assert property (p_halt_release)
    else $error("halt released without cause");

  // First expiry with warning high drives it low while halt stays high.
  property p_first_low;
    @(posedge CLOCK) disable iff (RST)
    (in_watch && expire && !kick_take && EXPIRY_WARNING_N && CPU_HALT_N)
      |=> (!EXPIRY_WARNING_N && CPU_HALT_N);
  endproperty
  a_first_low: assert property (p_first_low)
    else $error("warning did not start low phase");

  // The end of a low phase without a clear drops halt and raises warning.
  property p_halt_after_low;
    @(posedge CLOCK) disable iff (RST)
    (in_watch && expire && !kick_take && !EXPIRY_WARNING_N)
      |=> (!CPU_HALT_N && EXPIRY_WARNING_N);
  endproperty
  a_halt_after_low: assert property (p_halt_after_low)
    else $error("halt did not assert after low phase");

  // Once low in supervision, halt holds until a clear arrives.
  property p_halt_sticky;
    @(posedge CLOCK) disable iff (RST)
    (in_watch && !CPU_HALT_N && !kick_fall) |=> !CPU_HALT_N;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky)
    else $error("halt released without a clear");

  // The power-fail latch holds low until the upper threshold returns.
  property p_pf_latch;
    @(posedge CLOCK) disable iff (RST)
    (!POWER_FAIL_N && !UPPER_THRESHOLD_HIT) |=> !POWER_FAIL_N;
  endproperty
  a_pf_latch: assert property (p_pf_latch)
    else $error("power-fail released early");

  // Ticks are at least two cycles apart, and the count never passes the end.
  property p_tick_bound;
    @(posedge CLOCK) disable iff (RST)
    osc_tick |=> !osc_tick ##0 (tick_cnt_reg <= last_tick);
  endproperty
  a_tick_bound: assert property (p_tick_bound)
    else $error("tick spacing or count out of range");

endmodule

// ### bench/fwt_host_model.sv
// Host processor model that drives the watchdog clear pin.
`timescale 1ns/1ps
module fwt_host_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       kick_req,
  input  wire logic       loop_back,
  input  wire logic       idle_lvl,
  input  wire logic [7:0] low_len,
  input  wire logic [7:0] high_len,
  input  wire logic       warn_n,
  output logic            kick_n,
  output logic            busy
);
  logic [7:0] cnt_reg;
  logic [1:0] ph_reg;
  logic       pin_reg;

  // --------------------------------------------------------------------
  // Clear pin sequencer
  // --------------------------------------------------------------------
  // A clear is high, low, high, each phase held for its count. The pin never
  // changes faster than the minimum pulse width, even from a parked low level.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_reg <= 1'b1;
      cnt_reg <= 8'h00;
      ph_reg  <= 2'h0;
    end
    else if (cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;
    else if (ph_reg == 2'h0)
    begin
      pin_reg <= kick_req ? 1'b1 : idle_lvl;
      cnt_reg <= high_len;
      ph_reg  <= {1'b0, kick_req};
    end
    else if (ph_reg == 2'h1)
    begin
      pin_reg <= 1'b0;
      cnt_reg <= low_len;
      ph_reg  <= 2'h2;
    end
    else
    begin
      pin_reg <= 1'b1;
      cnt_reg <= high_len;
      ph_reg  <= 2'h0;
    end
  end

  // Loop-back turns the device into a plain voltage monitor.
  assign kick_n = loop_back ? warn_n : pin_reg;
  assign busy   = (ph_reg != 2'h0) | kick_req;
endmodule

// ### bench/tb_failsafe_watchdog_timer.sv
// Self-checking bench for the failsafe watchdog timer with a host model.
`timescale 1ns/1ps
module tb_failsafe_watchdog_timer;
  localparam int OSC = 48;
  localparam int TKS = 4;
  localparam int TUN = 6;
  localparam int T   = OSC * TKS;
  localparam int BSY = 4;
  localparam int KCK = 3;
  localparam int WRN = 2;
  localparam int HLT = 1;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 tune_open = 1'b1;
  fwt_pkg::fwt_levels_s lv = '0;
  logic                 kick_req = 1'b0;
  logic                 loop_back = 1'b0;
  logic                 idle_lvl = 1'b1;
  logic [7:0]           low_len = 8'h26;
  logic [7:0]           high_len = 8'h26;
  logic [1:0]           watch = 2'b00;
  logic                 kick_q = 1'b1;
  wire                  kick_n;
  wire                  busy;
  wire                  warn_n;
  wire                  halt_n;
  wire                  pf_n;
  wire  [4:0]           mon;
  int                   cyc = 0;
  int                   t_fall = 0;
  int                   t0;
  int                   n_mismatch = 0;
  int                   checked = 0;

  // --------------------------------------------------------------------
  // Clock, design and host
  // --------------------------------------------------------------------
  // Half period of 2 ns gives 250 MHz.
  always #2 clock = ~clock;

  fwt_watchdog #(.OSC_DIV(OSC), .EXPIRY_TKS(TKS), .TUNED_TKS(TUN), .CNT_W(8)) uut
  (
    .CLOCK                  (clock),
    .RST                    (rst),
    .KICK_IN_N              (kick_n),
    .OSC_TUNE_PIN_OPEN      (tune_open),
    .SUPPLY_GOOD_LEVEL      (lv.supply_good_level),
    .UPPER_THRESHOLD_HIT    (lv.upper_threshold_hit),
    .WARN_THRESHOLD_LOW     (lv.warn_threshold_low),
    .BELOW_CUTOFF_THRESHOLD (lv.below_cutoff),
    .EXPIRY_WARNING_N       (warn_n),
    .CPU_HALT_N             (halt_n),
    .POWER_FAIL_N           (pf_n)
  );

  fwt_host_model host
  (
    .clk       (clock),
    .rst       (rst),
    .kick_req  (kick_req),
    .loop_back (loop_back),
    .idle_lvl  (idle_lvl),
    .low_len   (low_len),
    .high_len  (high_len),
    .warn_n    (warn_n),
    .kick_n    (kick_n),
    .busy      (busy)
  );

  assign mon = {busy, kick_n, warn_n, halt_n, pf_n};

  // Cycle stamp, time of the last clear-pin fall and the steady-output watch.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    kick_q <= kick_n;
    if (kick_q === 1'b1 && kick_n === 1'b0)
      t_fall <= cyc;
    if ((watch[0] && halt_n !== 1'b1) || (watch[1] && warn_n !== 1'b1))
    begin
      n_mismatch++;
      $display("unexpected output drop expected 11 seen %b%b", warn_n, halt_n);
    end
  end

  // --------------------------------------------------------------------
  // Checking helpers
  // --------------------------------------------------------------------
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic near(input string what, input int exp, input int got, input int tol);
    checked++;
    if (got < exp - tol || got > exp + tol)
    begin
      n_mismatch++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Bounded wait at falling edges; running out ends the run.
  task automatic wt(input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (mon[i] !== v)
    begin
      if (k == lim)
      begin
        n_mismatch++;
        $display("unexpected wait on bit %0d expected %b seen %b", i, v, mon[i]);
        close_out();
      end
      @(negedge clock);
      k++;
    end
  endtask

  function automatic int period(input logic open);
    return OSC * (open ? TKS : TUN);
  endfunction

  // One clear with random phase lengths, never under the minimum width.
  task automatic kick();
    low_len  = 8'(fwt_pkg::KICK_MIN_CYCLES + $urandom % 8);
    high_len = 8'(fwt_pkg::KICK_MIN_CYCLES + $urandom % 16);
    kick_req = 1'b1;
    wt(KCK, 1'b1, 400);
    wt(KCK, 1'b0, 400);
    kick_req = 1'b0;
    wt(BSY, 1'b0, 400);
  endtask

  // Clears keep coming during power-up; they must not move the release.
  task automatic power_up(input logic open);
    t0 = cyc;
    kick_req = 1'b1;
    repeat (2) @(negedge clock);
    chk("power fail after power-up", 1'b1, pf_n);
    chk("halt held in power-up", 1'b0, halt_n);
    wt(HLT, 1'b1, 4 * T);
    near("release delay", period(open) + 2, cyc - t0, 3);
    kick_req = 1'b0;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hb36f023e));
    repeat (4) @(negedge clock);
    rst = 1'b0;
    chk("warning after reset", 1'b1, warn_n);
    chk("halt after reset", 1'b0, halt_n);
    chk("power fail after reset", 1'b0, pf_n);
    lv.supply_good_level = 1'b1;
    lv.upper_threshold_hit = 1'b1;
    power_up(1'b1);
    kick();
    watch = 2'b11;
    repeat (10) kick();
    watch = 2'b00;
    // Missed clears with the pin parked high, then parked low.
    for (int k = 0; k < 2; k++)
    begin
      idle_lvl = (k == 0);
      kick();
      wt(WRN, 1'b0, 3 * T);
      near("first warning delay", T + 5, cyc - t_fall, 3);
      t0 = cyc;
      wt(HLT, 1'b0, 2 * T);
      near("halt after low phase", T, cyc - t0, 2);
      wt(WRN, 1'b1, 4);
      near("warning low phase", T, cyc - t0, 2);
      wt(WRN, 1'b0, 2 * T);
      near("warning period", 2 * T, cyc - t0, 2);
      chk("halt stays low", 1'b0, halt_n);
      kick();
      chk("warning after clear", 1'b1, warn_n);
      chk("halt after clear", 1'b1, halt_n);
    end
    idle_lvl = 1'b1;
    loop_back = 1'b1;
    watch = 2'b01;
    wt(WRN, 1'b0, 2 * T);
    wt(WRN, 1'b1, 8);
    repeat (4 * T) @(negedge clock);
    watch = 2'b00;
    loop_back = 1'b0;
    kick();
    lv.upper_threshold_hit = 1'b0;
    lv.warn_threshold_low = 1'b1;
    repeat (2) @(negedge clock);
    chk("power fail below warn level", 1'b0, pf_n);
    chk("halt above cutoff", 1'b1, halt_n);
    lv.warn_threshold_low = 1'b0;
    repeat (2) @(negedge clock);
    chk("power fail held", 1'b0, pf_n);
    lv.below_cutoff = 1'b1;
    repeat (2) @(negedge clock);
    chk("halt at cutoff", 1'b0, halt_n);
    chk("power fail at cutoff", 1'b0, pf_n);
    chk("warning at cutoff", 1'b1, warn_n);
    kick();
    repeat (2 * T) @(negedge clock);
    chk("halt ignores clear", 1'b0, halt_n);
    chk("warning disabled", 1'b1, warn_n);
    lv.below_cutoff = 1'b0;
    lv.upper_threshold_hit = 1'b1;
    power_up(1'b1);
    lv.supply_good_level = 1'b0;
    tune_open = 1'b0;
    repeat (2) @(negedge clock);
    chk("halt on supply loss", 1'b0, halt_n);
    chk("power fail on supply loss", 1'b0, pf_n);
    watch = 2'b10;
    repeat (3 * T) @(negedge clock);
    watch = 2'b00;
    lv.supply_good_level = 1'b1;
    power_up(1'b0);
    // A reset in mid-run must bring back the power-up state from scratch.
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chk("halt after mid-run reset", 1'b0, halt_n);
    chk("warning after mid-run reset", 1'b1, warn_n);
    repeat (2) @(negedge clock);
    chk("power fail after mid-run reset", 1'b1, pf_n);
    chk("halt in mid-run power-up", 1'b0, halt_n);
    close_out();
  end
endmodule
